// >>> common/sram_host_pkg.sv
// constants and types shared by the async sram host controller
package sram_host_pkg;
  // =====================================================================
  // geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 16;
  localparam int LANE_W = 8;
  localparam int LANES  = 2;
  localparam int WORDS  = 32768;
  // =====================================================================
  // timing, in ns as printed, and clock figures
  localparam int CLK_PERIOD_NS                = 20;
  localparam int WRITE_STROBE_TURNOFF_DELAY_NS = 4;
  localparam int WRITE_DATA_SETUP_NS          = 8;
  localparam int READ_ACCESS_NS               = 15;
  localparam int WRITE_PULSE_NS               = 10;
  function automatic int ceil_cycles(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1 ? 1
         : (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction
  // write pulse must cover turnoff plus setup, and the plain pulse width
  localparam int WRITE_LOW_NS = (WRITE_STROBE_TURNOFF_DELAY_NS + WRITE_DATA_SETUP_NS)
                                > WRITE_PULSE_NS
                              ? (WRITE_STROBE_TURNOFF_DELAY_NS + WRITE_DATA_SETUP_NS)
                              : WRITE_PULSE_NS;
  localparam int WRITE_CYCLES = ceil_cycles(WRITE_LOW_NS);
  // one extra cycle lets the pins settle through the input synchroniser
  localparam int READ_CYCLES  = ceil_cycles(READ_ACCESS_NS) + 1;
  localparam int CNT_W        = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE  = 4'h1;
  localparam logic [LANES-1:0] LANES_OFF = 2'h3;
  // =====================================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_WRITE,
    ST_WHOLD,
    ST_READ,
    ST_RDONE
  } state_t;
endpackage

// >>> common/sram_pins_if.sv
// pin group between the sequencer and the pad stage
interface sram_pins_if;
  logic [sram_host_pkg::ADDR_W-1:0] address;
  logic                             chipSelectN;
  logic                             outputEnableN;
  logic                             writeEnableN;
  logic                             lowerLaneEnableN;
  logic                             upperLaneEnableN;
  logic [sram_host_pkg::DATA_W-1:0] dataOut;
  logic                             dataDrive;
  logic [sram_host_pkg::DATA_W-1:0] dataSync;
  modport seq (
    output address, chipSelectN, outputEnableN, writeEnableN,
    output lowerLaneEnableN, upperLaneEnableN, dataOut, dataDrive,
    input  dataSync
  );
  modport pad (
    input  address, chipSelectN, outputEnableN, writeEnableN,
    input  lowerLaneEnableN, upperLaneEnableN, dataOut, dataDrive,
    output dataSync
  );
endinterface

// >>> rtl/sram_data_sync.sv
// two-flop synchroniser for the data pins returned by the memory
module sram_data_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic rst_b,
  // pins and sequencer side
  input  wire logic [sram_host_pkg::DATA_W-1:0] dataIn,
  sram_pins_if.pad  pins
);
  // =====================================================================
  // synchroniser
  logic [sram_host_pkg::DATA_W-1:0] stage1;
  logic [sram_host_pkg::DATA_W-1:0] stage2;
  logic [sram_host_pkg::DATA_W-1:0] next_stage1;
  logic [sram_host_pkg::DATA_W-1:0] next_stage2;

  always_comb begin
    next_stage1 = dataIn;
    next_stage2 = stage1;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign pins.dataSync = stage2;
endmodule // sram_data_sync

// >>> rtl/sram_host.sv
// host controller driving an asynchronous 32k x 16 sram with byte lanes
// Functional notes
// RULE1 - memory holds 32768 words of 16 bits, two byte lanes, 15-bit address
// RULE2 - chip select high deselects memory; its data pins float
// RULE3 - read: select and output enable low, write high; lanes with enable low drive
// RULE4 - write: select and write low; enabled lanes take data whatever output enable
// RULE5 - selected with output enable high or both lanes off: pins float
// RULE6 - write starts on select, write and a lane low; lasts during overlap
// RULE7 - write ends when any qualifying strobe returns inactive
// RULE8 - data setup and hold count from the strobe that ends the write
// RULE9 - select and write rising together leaves pins floating
// RULE10 - write strobe held low at least 4 ns plus 8 ns
// RULE11 - host never drives data while the memory drives during a read
// RULE12 - read address valid no later than select falling
// RULE13 - write enable stays high throughout a read
// RULE14 - address stable over the write overlap, changed after terminating edge
module sram_host #(
  parameter int WRITE_CYCLES = sram_host_pkg::WRITE_CYCLES,
  parameter int READ_CYCLES  = sram_host_pkg::READ_CYCLES
) (
  // clock and reset
  input  wire logic                             clock,
  input  wire logic                             rst_b,
  // user request
  input  wire logic                             reqValid,
  input  wire logic                             reqWrite,
  input  wire logic [sram_host_pkg::ADDR_W-1:0] reqAddress,
  input  wire logic [sram_host_pkg::DATA_W-1:0] reqData,
  input  wire logic [sram_host_pkg::LANES-1:0]  reqLaneEnable,
  output      logic                             reqReady,
  // user answer
  output      logic                             rspValid,
  output      logic [sram_host_pkg::DATA_W-1:0] rspData,
  // memory pins
  output      logic [sram_host_pkg::ADDR_W-1:0] memAddress,
  output      logic                             chipSelectN,
  output      logic                             outputEnableN,
  output      logic                             writeEnableN,
  output      logic                             lowerLaneEnableN,
  output      logic                             upperLaneEnableN,
  input  wire logic [sram_host_pkg::DATA_W-1:0] memDataIn,
  output      logic [sram_host_pkg::DATA_W-1:0] memDataOut,
  output      logic                             memDataOe
);
  // =====================================================================
  // pin group and synchroniser
  sram_pins_if pins ();

  sram_data_sync u_sync (
    .clock  (clock),
    .rst_b  (rst_b),
    .dataIn (memDataIn),
    .pins   (pins.pad)
  );

  // =====================================================================
  // sequencer state
  sram_host_pkg::state_t                    state;
  sram_host_pkg::state_t                    next_state;
  logic [sram_host_pkg::CNT_W-1:0]          count;
  logic [sram_host_pkg::CNT_W-1:0]          next_count;
  logic [sram_host_pkg::ADDR_W-1:0]         address;
  logic [sram_host_pkg::ADDR_W-1:0]         next_address;
  logic [sram_host_pkg::DATA_W-1:0]         wdata;
  logic [sram_host_pkg::DATA_W-1:0]         next_wdata;
  logic [sram_host_pkg::LANES-1:0]          laneN;
  logic [sram_host_pkg::LANES-1:0]          next_laneN;
  logic                                     isWrite;
  logic                                     next_isWrite;
  logic [sram_host_pkg::DATA_W-1:0]         rdata;
  logic [sram_host_pkg::DATA_W-1:0]         next_rdata;
  logic                                     rvalid;
  logic                                     next_rvalid;

  // strobe registers, so every pin comes from a flip-flop
  logic csN;
  logic next_csN;
  logic oeN;
  logic next_oeN;
  logic weN;
  logic next_weN;
  logic drive;
  logic next_drive;

  localparam logic [sram_host_pkg::CNT_W-1:0] WRITE_LOAD =
    sram_host_pkg::CNT_W'(WRITE_CYCLES - 1);
  localparam logic [sram_host_pkg::CNT_W-1:0] READ_LOAD =
    sram_host_pkg::CNT_W'(READ_CYCLES - 1);

  always_comb begin
    next_state   = state;
    next_count   = count;
    next_address = address;
    next_wdata   = wdata;
    next_laneN   = laneN;
    next_isWrite = isWrite;
    next_rdata   = rdata;
    next_rvalid  = 1'b0;
    next_csN     = 1'b1;
    next_oeN     = 1'b1;
    next_weN     = 1'b1;
    next_drive   = 1'b0;
    unique case (state)
      sram_host_pkg::ST_IDLE: begin
        // an empty lane mask would never open a write; it still completes
        if (reqValid) begin
          next_address = reqAddress;                              // see RULE1
          next_wdata   = reqData;
          next_laneN   = ~reqLaneEnable;
          next_isWrite = reqWrite;
          next_state   = sram_host_pkg::ST_SETUP;
        end
      end
      sram_host_pkg::ST_SETUP: begin
        // address settled a cycle before select falls                see RULE12
        next_csN = 1'b0;
        if (isWrite) begin
          next_weN   = 1'b0;                                      // see RULE6
          next_oeN   = 1'b1;
          next_drive = 1'b1;                                      // see RULE4
          next_count = WRITE_LOAD;
          next_state = sram_host_pkg::ST_WRITE;
        end else begin
          next_oeN   = 1'b0;                                      // see RULE3
          next_weN   = 1'b1;                                      // see RULE13
          next_count = READ_LOAD;
          next_state = sram_host_pkg::ST_READ;
        end
      end
      sram_host_pkg::ST_WRITE: begin
        next_csN   = 1'b0;
        next_drive = 1'b1;
        if (count != sram_host_pkg::CNT_ZERO) begin
          // held low long enough for turnoff plus setup              see RULE10
          next_weN   = 1'b0;
          next_count = count - sram_host_pkg::CNT_ONE;
        end else begin
          // write enable alone ends the write; data and address held  see RULE8
          next_weN   = 1'b1;                                      // see RULE7
          next_state = sram_host_pkg::ST_WHOLD;
        end
      end
      sram_host_pkg::ST_WHOLD: begin
        // select released one cycle after write enable; address kept  see RULE14
        next_laneN = sram_host_pkg::LANES_OFF;
        next_state = sram_host_pkg::ST_IDLE;
      end
      sram_host_pkg::ST_READ: begin
        // data bus left to the memory                                see RULE11
        next_csN = 1'b0;
        next_oeN = 1'b0;
        if (count != sram_host_pkg::CNT_ZERO) begin
          next_count = count - sram_host_pkg::CNT_ONE;
        end else begin
          next_state = sram_host_pkg::ST_RDONE;
        end
      end
      sram_host_pkg::ST_RDONE: begin
        // synchronised pins now show the word sampled while selected
        next_rdata  = pins.dataSync;
        next_rvalid = 1'b1;
        next_laneN  = sram_host_pkg::LANES_OFF;
        next_state  = sram_host_pkg::ST_IDLE;
      end
      default: next_state = sram_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state   <= sram_host_pkg::ST_IDLE;
      count   <= sram_host_pkg::CNT_ZERO;
      address <= '0;
      wdata   <= '0;
      laneN   <= sram_host_pkg::LANES_OFF;
      isWrite <= 1'b0;
      rdata   <= '0;
      rvalid  <= 1'b0;
      csN     <= 1'b1;                                            // see RULE2
      oeN     <= 1'b1;
      weN     <= 1'b1;
      drive   <= 1'b0;
    end else begin
      state   <= next_state;
      count   <= next_count;
      address <= next_address;
      wdata   <= next_wdata;
      laneN   <= next_laneN;
      isWrite <= next_isWrite;
      rdata   <= next_rdata;
      rvalid  <= next_rvalid;
      csN     <= next_csN;
      oeN     <= next_oeN;
      weN     <= next_weN;
      drive   <= next_drive;
    end
  end

  // =====================================================================
  // pins
  assign pins.address          = address;
  assign pins.chipSelectN      = csN;
  assign pins.outputEnableN    = oeN;
  assign pins.writeEnableN     = weN;
  // oe held high during writes so the memory never drives    see RULE5
  assign pins.lowerLaneEnableN = laneN[0];
  assign pins.upperLaneEnableN = laneN[1];
  assign pins.dataOut          = wdata;
  assign pins.dataDrive        = drive;                            // see RULE9

  assign memAddress       = pins.address;
  assign chipSelectN      = pins.chipSelectN;
  assign outputEnableN    = pins.outputEnableN;
  assign writeEnableN     = pins.writeEnableN;
  assign lowerLaneEnableN = pins.lowerLaneEnableN;
  assign upperLaneEnableN = pins.upperLaneEnableN;
  assign memDataOut       = pins.dataOut;
  assign memDataOe        = pins.dataDrive;

  assign reqReady = (state == sram_host_pkg::ST_IDLE);
  assign rspValid = rvalid;
  assign rspData  = rdata;
endmodule // sram_host

// >>> testbench/sram_model.sv
// behavioural async static memory with byte lanes, far side of the host
module sram_model (
  // pacing of the floating-bus pattern
  input  wire logic        clock,
  // memory pins
  input  wire logic [14:0] address,
  input  wire logic        chipSelectN,
  input  wire logic        outputEnableN,
  input  wire logic        writeEnableN,
  input  wire logic        lowerLaneEnableN,
  input  wire logic        upperLaneEnableN,
  input  wire logic [15:0] hostData,
  input  wire logic        hostDrive,
  // resolved data wire
  output      logic [15:0] bus
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [32768];
  logic [15:0] last = 16'h0000;
  logic [1:0]  laneN;
  logic        rdOn;
  assign laneN = {upperLaneEnableN, lowerLaneEnableN};
  assign rdOn = !chipSelectN && !outputEnableN && writeEnableN;
  // ========
  // wire: host first, then memory lanes; a floating lane toggles so it never looks held
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      if (hostDrive)
        bus[8*i +: 8] = hostData[8*i +: 8];
      else if (rdOn && !laneN[i])
        bus[8*i +: 8] = mem[address][8*i +: 8];
      else
        bus[8*i +: 8] = ~last[8*i +: 8];
    end
  end
  // level write over the overlap: the value at the ending edge is what stays
  always @* begin
    if (!chipSelectN && !writeEnableN) begin
      for (int i = 0; i < 2; i++) begin
        if (!laneN[i])
          mem[address][8*i +: 8] = bus[8*i +: 8];
      end
    end
  end
  always @(posedge clock) last <= bus;
endmodule // sram_model

// >>> testbench/sram_host_properties.sv
// assertions on the pins of the sram host controller
module sram_host_properties #(
  parameter int WRITE_CYCLES = sram_host_pkg::WRITE_CYCLES,
  parameter int READ_CYCLES  = sram_host_pkg::READ_CYCLES
) (
  // clock and reset
  input wire logic        clock,
  input wire logic        rst_b,
  // user side
  input wire logic        reqValid,
  input wire logic        reqWrite,
  input wire logic [14:0] reqAddress,
  input wire logic [15:0] reqData,
  input wire logic [1:0]  reqLaneEnable,
  input wire logic        reqReady,
  input wire logic        rspValid,
  // memory pins
  input wire logic [14:0] memAddress,
  input wire logic        chipSelectN,
  input wire logic        outputEnableN,
  input wire logic        writeEnableN,
  input wire logic        lowerLaneEnableN,
  input wire logic        upperLaneEnableN,
  input wire logic [15:0] memDataOut,
  input wire logic        memDataOe
);
  timeunit 1ns;
  timeprecision 1ns;
  // ========
  // copy of the taken request, so pin values tie back to their cause
  logic        take;
  logic [14:0] tAddr;
  logic [15:0] tData;
  logic [1:0]  tLane;
  assign take = reqValid && reqReady;
  always_ff @(posedge clock) begin
    if (take) begin
      tAddr <= reqAddress;
      tData <= reqData;
      tLane <= reqLaneEnable;
    end
  end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  AST_NO_CONTENTION: assert property (!chipSelectN && !outputEnableN |-> !memDataOe)
    else $error("host drives data during a read");
  AST_READ_WE_HIGH: assert property (!outputEnableN |-> writeEnableN && !chipSelectN)
    else $error("write strobe low during a read");
  AST_ADDR_STABLE: assert property (!chipSelectN |-> $stable(memAddress))
    else $error("address moved while selected");
  AST_SELECT_TARGET: assert property ($fell(chipSelectN) |-> memAddress == tAddr
    && {upperLaneEnableN, lowerLaneEnableN} == ~tLane) else $error("wrong address or lanes");
  AST_WRITE_START: assert property (take && reqWrite |=> (!reqReady && outputEnableN)[*2]
    ##[0:2] (!chipSelectN && !writeEnableN && memDataOe)) else $error("write overlap missing");
  AST_WRITE_PULSE: assert property ($fell(writeEnableN) |-> !chipSelectN && memDataOe
    && outputEnableN && memDataOut == tData) else $error("write pulse badly qualified");
  AST_TERMINATE_HOLD: assert property ($rose(writeEnableN) |-> !chipSelectN && memDataOe
    && $stable(memDataOut)) else $error("data not held at write end");
  AST_READ_FLOW: assert property (take && !reqWrite |-> writeEnableN
    throughout (1'b1 ##[4:6] rspValid)) else $error("read answer late or write strobe low");
endmodule // sram_host_properties

bind sram_host sram_host_properties #(.WRITE_CYCLES(WRITE_CYCLES), .READ_CYCLES(READ_CYCLES)) chk (
  .clock(clock), .rst_b(rst_b), .reqValid(reqValid), .reqWrite(reqWrite),
  .reqAddress(reqAddress), .reqData(reqData), .reqLaneEnable(reqLaneEnable),
  .reqReady(reqReady), .rspValid(rspValid), .memAddress(memAddress),
  .chipSelectN(chipSelectN), .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
  .lowerLaneEnableN(lowerLaneEnableN), .upperLaneEnableN(upperLaneEnableN),
  .memDataOut(memDataOut), .memDataOe(memDataOe)
);

// >>> testbench/tb.sv
// self-checking bench for the sram host controller against a memory model
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst_b, reqValid, reqWrite, reqReady, rspValid, memDataOe;
  logic        chipSelectN, outputEnableN, writeEnableN, lowerLaneEnableN, upperLaneEnableN;
  logic [14:0] reqAddress, memAddress;
  logic [15:0] reqData, rspData, memDataIn, memDataOut;
  logic [1:0]  reqLaneEnable;
  int          failures = 0;
  int          compares = 0;
  sram_host uut (
    .clock(clock), .rst_b(rst_b), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqAddress(reqAddress), .reqData(reqData), .reqLaneEnable(reqLaneEnable),
    .reqReady(reqReady), .rspValid(rspValid), .rspData(rspData), .memAddress(memAddress),
    .chipSelectN(chipSelectN), .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
    .lowerLaneEnableN(lowerLaneEnableN), .upperLaneEnableN(upperLaneEnableN),
    .memDataIn(memDataIn), .memDataOut(memDataOut), .memDataOe(memDataOe)
  );
  sram_model dev (
    .clock(clock), .address(memAddress), .chipSelectN(chipSelectN),
    .outputEnableN(outputEnableN), .writeEnableN(writeEnableN),
    .lowerLaneEnableN(lowerLaneEnableN), .upperLaneEnableN(upperLaneEnableN),
    .hostData(memDataOut), .hostDrive(memDataOe), .bus(memDataIn)
  );
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  // ========
  // verdict and compare
  task automatic close_out;
    if (failures == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_word(input string name, input logic [15:0] exp, got, mask);
    compares++;
    if ((got & mask) !== (exp & mask)) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp & mask, got & mask);
    end
  endtask
  // writes keep reqValid up so the next request follows at once; reads drop it
  task automatic send(input logic wr, input logic [14:0] a, input logic [15:0] d,
                      input logic [1:0] ln, output logic [15:0] rd);
    int n;
    reqValid <= 1'b1;
    reqWrite <= wr;
    reqAddress <= a;
    reqData <= d;
    reqLaneEnable <= ln;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (reqReady !== 1'b1 && n < 20);
    @(posedge clock);
    rd = 16'h0000;
    if (!wr) begin
      reqValid <= 1'b0;
      do begin
        @(negedge clock);
        n++;
      end while (rspValid !== 1'b1 && n < 40);
      rd = rspData;
      @(posedge clock);
    end
    if (n >= 20 + (wr ? 0 : 20)) begin
      failures++;
      $display("BAD handshake cycles expected below %0d seen %0d", 20 + (wr ? 0 : 20), n);
    end
  endtask
  // ========
  // scenarios
  task automatic t_ends;
    logic [15:0] r;
    send(1'b1, 15'h0000, 16'ha5c3, 2'h3, r);
    send(1'b1, 15'h7fff, 16'h3cf0, 2'h3, r);
    send(1'b0, 15'h0000, 16'h0000, 2'h3, r);
    check_word("word first", 16'ha5c3, r, 16'hffff);
    send(1'b0, 15'h7fff, 16'h0000, 2'h3, r);
    check_word("word last", 16'h3cf0, r, 16'hffff);
  endtask
  task automatic t_lanes;
    logic [15:0] r;
    logic [1:0]  ln;
    send(1'b1, 15'h0005, 16'h1111, 2'h3, r);
    send(1'b1, 15'h0005, 16'haa55, 2'h1, r);
    send(1'b1, 15'h0005, 16'h66bb, 2'h2, r);
    for (int k = 3; k > 0; k--) begin
      ln = k[1:0];
      send(1'b0, 15'h0005, 16'h0000, ln, r);
      check_word("lane read", 16'h6655, r, {{8{ln[1]}}, {8{ln[0]}}});
    end
  endtask
  task automatic t_none;
    logic [15:0] r;
    send(1'b1, 15'h0005, 16'h0000, 2'h0, r);
    send(1'b0, 15'h0005, 16'h0000, 2'h3, r);
    check_word("no lane write", 16'h6655, r, 16'hffff);
  endtask
  initial begin
    rst_b = 1'b0;
    reqValid = 1'b0;
    reqWrite = 1'b0;
    reqAddress = 15'h0000;
    reqData = 16'h0000;
    reqLaneEnable = 2'h0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    t_ends();
    t_lanes();
    t_none();
    close_out();
  end
  // the whole run needs under a hundred cycles; 5000 is a hang
  initial begin
    #100000;
    failures++;
    close_out();
  end
endmodule // tb
